// >>> src/frpc_pkg.sv
// Behaviour
// - rewrite enable forces expand bit, restores later
// - entering rewrite sets block A and expand
// - byte programming only in parallel mode
// - block A enable moves chip select two
// - boot area rewritable only in parallel mode
// - strap pattern at reset enters boot mode
// - boot select low: user area, boot hidden
// - boot mode area chosen by select bit
// - protect active blocks parallel read and rewrite
// - release field 00b removes protection
// - release field frozen in protected parallel mode
// - protect bits only clear, successful user-block erase sets FFh
// - enable pair honoured for release 01b-11b
// - id mismatch rejects serial and can programmer commands unless flash is blank
// - id bytes read from fixed addresses; here only the address constants exist, the check comes in on pgm_id_ok
// - cpu rewrite touches user blocks only
// - post-operation mode depends on variant
// - in-place variant holds cpu during operation
// - ready and error flags exposed in registers
// - enable set only by 0 then 1
// - area select: 0 boot read, 1 user
// - ready low while busy, ctrl0 errors sticky; status fail bits follow the last failure
// - clearing enable clears variant select
package frpc_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_FCTRL0 = 8'h00;
   localparam logic [7:0] OFF_FCTRL1 = 8'h04;
   localparam logic [7:0] OFF_PMODE = 8'h08;
   localparam logic [7:0] OFF_PROT = 8'h0C;
   localparam logic [7:0] OFF_CMD = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h14;
   localparam logic [7:0] OFF_MAP = 8'h18;
   localparam logic [7:0] OFF_ID = 8'h1C;
   // ctrl0 bit positions
   localparam int B_READY = 0;
   localparam int B_RWEN = 1;
   localparam int B_LOCKOVR = 2;
   localparam int B_AREASEL = 5;
   localparam int B_PERR = 6;
   localparam int B_EERR = 7;
   // ctrl1 / pmode positions
   localparam int B_ALTVAR = 1;
   localparam int B_BLKA = 0;
   localparam int B_EXPAND = 3;
   // status register positions
   localparam int B_SR_READY = 7;
   localparam int B_SR_EFAIL = 5;
   localparam int B_SR_PFAIL = 4;
   // protect register layout and reset
   localparam int B_PEN_LO = 6;
   localparam int B_REL_LO = 4;
   localparam logic [7:0] PROT_RST = 8'hFF;
   localparam logic [1:0] REL_OFF = 2'b00;
   localparam logic [1:0] PEN_OFF = 2'b11;
   // id byte addresses, first and last
   localparam logic [23:0] ID_ADDR_FIRST = 24'h0F_FFDF;
   localparam logic [23:0] ID_ADDR_LAST = 24'h0F_FFFB;
   // chip select two window with block A enabled
   localparam logic [23:0] CS_TWO_LO = 24'h01_0000;
   localparam logic [23:0] CS_TWO_HI = 24'h02_6FFF;
   // command codes
   localparam logic [1:0] CMD_PROG = 2'd1;
   localparam logic [1:0] CMD_ERASE = 2'd2;
   localparam logic [1:0] CMD_CLR = 2'd3;
   // programming modes from the pins
   typedef enum logic [1:0] {
      FRPC_PM_CPU = 2'd0,
      FRPC_PM_SERIAL = 2'd1,
      FRPC_PM_PARALLEL = 2'd2,
      FRPC_PM_CAN = 2'd3
   } frpc_pmode_t;
   // sequencer states
   typedef enum logic [2:0] {
      FRPC_IDLE = 3'b001,
      FRPC_BUSY = 3'b010,
      FRPC_DONE = 3'b100
   } frpc_state_t;
   // read mode after completion
   typedef enum logic {
      FRPC_RD_ARRAY = 1'b0,
      FRPC_RD_STATUS = 1'b1
   } frpc_rdmode_t;
   // operation request to the flash core
   typedef struct packed {
      logic start;
      logic erase;
      logic byte_mode;
      logic boot_area;
   } frpc_op_t;
endpackage

// >>> src/frpc_top.sv
`timescale 1ns/1ps
`default_nettype none
module frpc_top #(
   parameter int OP_CYCLES = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // strap pins and programming mode
   input wire logic boot_select_pin,
   input wire logic boot_strap_low_pin,
   input wire logic boot_strap_high_pin,
   input wire logic [1:0] prog_mode,
   // flash core result
   input wire logic op_fail,
   input wire logic flash_blank,
   // programmer side
   input wire logic pgm_req,
   input wire logic pgm_id_ok,
   output logic pgm_accept,
   output logic pgm_read_ok,
   output logic pgm_write_ok,
   // flash core and system
   output logic op_start,
   output logic op_erase,
   output logic op_byte,
   output logic boot_mode,
   output logic boot_readable,
   output logic cpu_hold,
   output logic block_a_mapped,
   output logic [23:0] cs_two_lo,
   output logic [23:0] cs_two_hi,
   output logic ext_expand
);
   frpc_pkg::frpc_state_t st_q, st_d;
   logic [7:0] ctrl0_q, ctrl1_q, pm_q, prot_q, sr_q;
   logic [7:0] cnt_q;
   logic arm_rw_q, arm_alt_q, arm_lk_q, strap_q, boot_q;
   logic expand_save_q, rdmode_q;
   logic aph_q, wr_q;
   logic [7:0] adr_q;
   logic [7:0] wdat;
   frpc_pkg::frpc_op_t op_q;
   logic [7:0] hr_q;

   // address phase capture
   wire take = hsel & hready & htrans[1];
   wire wr_ctrl0 = aph_q & wr_q & (adr_q == frpc_pkg::OFF_FCTRL0);
   wire wr_ctrl1 = aph_q & wr_q & (adr_q == frpc_pkg::OFF_FCTRL1);
   wire wr_pm = aph_q & wr_q & (adr_q == frpc_pkg::OFF_PMODE);
   wire wr_prot = aph_q & wr_q & (adr_q == frpc_pkg::OFF_PROT);
   wire wr_cmd = aph_q & wr_q & (adr_q == frpc_pkg::OFF_CMD);
   assign wdat = hwdata[7:0];

   // mode decoding
   wire rwen = ctrl0_q[frpc_pkg::B_RWEN];
   wire parallel = prog_mode == frpc_pkg::FRPC_PM_PARALLEL;
   wire ser_can = (prog_mode == frpc_pkg::FRPC_PM_SERIAL) |
                  (prog_mode == frpc_pkg::FRPC_PM_CAN);
   wire [1:0] rel = prot_q[frpc_pkg::B_REL_LO +: 2];
   wire [1:0] pen = prot_q[frpc_pkg::B_PEN_LO +: 2];
   // pair only counts when release is 01b..11b
   wire prot_on = (rel != frpc_pkg::REL_OFF) & (pen != frpc_pkg::PEN_OFF);
   wire par_block = parallel & prot_on;
   wire inplace = ctrl1_q[frpc_pkg::B_ALTVAR];
   wire busy = st_q == frpc_pkg::FRPC_BUSY;
   // boot area only when parallel; cpu rewrite aims at user blocks
   wire tgt_boot = boot_q & ~ctrl0_q[frpc_pkg::B_AREASEL];
   wire cmd_ok = wr_cmd & ~busy & ((rwen & ~tgt_boot) | (parallel & ~par_block));
   wire go = cmd_ok & ((wdat[1:0] == frpc_pkg::CMD_PROG) | (wdat[1:0] == frpc_pkg::CMD_ERASE));
   wire fin = busy & (cnt_q == 8'(OP_CYCLES - 1));

   // unlock sequences: write 0 then 1 on the same register; a write to the other control register between breaks the pair, except for lock override
   wire rw0 = wr_ctrl0 & ~wdat[frpc_pkg::B_RWEN];
   wire rw1 = wr_ctrl0 & wdat[frpc_pkg::B_RWEN] & arm_rw_q;
   wire rw_clr = rw0 & rwen;
   wire alt1 = wr_ctrl1 & wdat[frpc_pkg::B_ALTVAR] & arm_alt_q & rwen;
   wire lk1 = wr_ctrl0 & wdat[frpc_pkg::B_LOCKOVR] & arm_lk_q & rwen;

   // sequencer next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         frpc_pkg::FRPC_IDLE: if (go) st_d = frpc_pkg::FRPC_BUSY;
         frpc_pkg::FRPC_BUSY: if (fin) st_d = frpc_pkg::FRPC_DONE;
         frpc_pkg::FRPC_DONE: st_d = frpc_pkg::FRPC_IDLE;
         default: st_d = frpc_pkg::FRPC_IDLE;
      endcase
   end

   // bus pipeline, response always okay and zero wait
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph_q <= 1'b0;
         wr_q <= 1'b0;
         adr_q <= 8'h00;
      end else if (hready) begin
         aph_q <= take;
         wr_q <= hwrite;
         adr_q <= haddr[7:0];
      end
   end

   // read mux
   wire [7:0] rd_ctrl0 = ctrl0_q;
   wire [7:0] rd_sel =
      (haddr[7:0] == frpc_pkg::OFF_FCTRL0) ? rd_ctrl0 :
      (haddr[7:0] == frpc_pkg::OFF_FCTRL1) ? ctrl1_q :
      (haddr[7:0] == frpc_pkg::OFF_PMODE) ? pm_q :
      (haddr[7:0] == frpc_pkg::OFF_PROT) ? (par_block ? 8'h00 : prot_q) :
      // status reads are not available in the in-place variant
      (haddr[7:0] == frpc_pkg::OFF_STAT) ? (inplace ? 8'h00 : sr_q) :
      (haddr[7:0] == frpc_pkg::OFF_MAP) ? {5'h00, ~boot_q | ctrl0_q[frpc_pkg::B_AREASEL],
                                           boot_q, rdmode_q} :
      8'h00;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) hr_q <= 8'h00;
      else if (take & ~hwrite) hr_q <= rd_sel;
   end

   // strap capture one cycle after release, not in the reset branch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_q <= 1'b0;
         boot_q <= 1'b0;
      end else if (!strap_q) begin
         strap_q <= 1'b1;
         boot_q <= boot_select_pin & boot_strap_high_pin & ~boot_strap_low_pin;
      end
   end

   // flash control register 0
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl0_q <= 8'h01;
         arm_rw_q <= 1'b0;
         arm_lk_q <= 1'b0;
      end else begin
         if (wr_ctrl0) begin
            arm_rw_q <= rw0;
            arm_lk_q <= ~wdat[frpc_pkg::B_LOCKOVR];
            if (rw1) ctrl0_q[frpc_pkg::B_RWEN] <= 1'b1;
            else if (rw0) ctrl0_q[frpc_pkg::B_RWEN] <= 1'b0;
            if (lk1) ctrl0_q[frpc_pkg::B_LOCKOVR] <= 1'b1;
            else if (~wdat[frpc_pkg::B_LOCKOVR]) ctrl0_q[frpc_pkg::B_LOCKOVR] <= 1'b0;
            ctrl0_q[frpc_pkg::B_AREASEL] <= wdat[frpc_pkg::B_AREASEL];
         end else if (wr_ctrl1) begin
            arm_rw_q <= 1'b0;
         end
         ctrl0_q[frpc_pkg::B_READY] <= ~(st_d == frpc_pkg::FRPC_BUSY);
         // completion sets error, clear command loses to a same-cycle set
         if (fin & op_fail & ~op_q.erase) ctrl0_q[frpc_pkg::B_PERR] <= 1'b1;
         else if (cmd_ok & (wdat[1:0] == frpc_pkg::CMD_CLR)) ctrl0_q[frpc_pkg::B_PERR] <= 1'b0;
         if (fin & op_fail & op_q.erase) ctrl0_q[frpc_pkg::B_EERR] <= 1'b1;
         else if (cmd_ok & (wdat[1:0] == frpc_pkg::CMD_CLR)) ctrl0_q[frpc_pkg::B_EERR] <= 1'b0;
      end
   end

   // flash control register 1, cleared with the enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl1_q <= 8'h00;
         arm_alt_q <= 1'b0;
      end else if (rw_clr) begin
         ctrl1_q[frpc_pkg::B_ALTVAR] <= 1'b0;
         arm_alt_q <= 1'b0;
      end else if (wr_ctrl1) begin
         arm_alt_q <= ~wdat[frpc_pkg::B_ALTVAR];
         if (alt1) ctrl1_q[frpc_pkg::B_ALTVAR] <= 1'b1;
         else if (~wdat[frpc_pkg::B_ALTVAR]) ctrl1_q[frpc_pkg::B_ALTVAR] <= 1'b0;
      end else if (wr_ctrl0) begin
         arm_alt_q <= 1'b0;
      end
   end

   // processor mode register 2; expand is held while rewriting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pm_q <= 8'h00;
         expand_save_q <= 1'b0;
      end else begin
         if (rw1 & ~rwen) begin
            pm_q[frpc_pkg::B_BLKA] <= 1'b1;
            pm_q[frpc_pkg::B_EXPAND] <= 1'b1;
            expand_save_q <= pm_q[frpc_pkg::B_EXPAND];
         end else if (rw_clr) begin
            pm_q[frpc_pkg::B_EXPAND] <= expand_save_q;
            pm_q[frpc_pkg::B_BLKA] <= pm_q[frpc_pkg::B_BLKA];
         end else if (wr_pm) begin
            pm_q[frpc_pkg::B_BLKA] <= wdat[frpc_pkg::B_BLKA];
            // later writes are deferred until the enable clears
            if (rwen) expand_save_q <= wdat[frpc_pkg::B_EXPAND];
            else pm_q[frpc_pkg::B_EXPAND] <= wdat[frpc_pkg::B_EXPAND];
         end
      end
   end

   // protect register: bits only fall, successful user-block erase restores all ones
   wire prot_erase = fin & op_q.erase & ~op_q.boot_area & ~op_fail;
   wire rel_frozen = parallel & prot_on;
   wire [7:0] prot_w = {wdat[7:6], rel_frozen ? rel : wdat[5:4], wdat[3:0]};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) prot_q <= frpc_pkg::PROT_RST;
      else if (prot_erase) prot_q <= frpc_pkg::PROT_RST;
      // a protected parallel programmer may not touch the protect byte at all
      else if (wr_prot & ~par_block) prot_q <= prot_q & prot_w;
   end

   // sequencer, status and operation
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= frpc_pkg::FRPC_IDLE;
         cnt_q <= 8'h00;
         sr_q <= 8'h80;
         op_q <= '0;
         rdmode_q <= frpc_pkg::FRPC_RD_ARRAY;
      end else begin
         st_q <= st_d;
         cnt_q <= busy ? cnt_q + 8'h01 : 8'h00;
         op_q.start <= go;
         if (go) begin
            op_q.erase <= wdat[1:0] == frpc_pkg::CMD_ERASE;
            op_q.byte_mode <= parallel & wdat[2];
            op_q.boot_area <= tgt_boot;
         end
         sr_q[frpc_pkg::B_SR_READY] <= ~(st_d == frpc_pkg::FRPC_BUSY);
         if (fin & op_fail) begin
            sr_q[frpc_pkg::B_SR_EFAIL] <= op_q.erase;
            sr_q[frpc_pkg::B_SR_PFAIL] <= ~op_q.erase;
         end else if (cmd_ok & (wdat[1:0] == frpc_pkg::CMD_CLR)) begin
            sr_q[frpc_pkg::B_SR_EFAIL] <= 1'b0;
            sr_q[frpc_pkg::B_SR_PFAIL] <= 1'b0;
         end
         if (fin) rdmode_q <= inplace ? frpc_pkg::FRPC_RD_ARRAY : frpc_pkg::FRPC_RD_STATUS;
      end
   end

   // registered outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pgm_accept <= 1'b0;
         pgm_read_ok <= 1'b0;
         pgm_write_ok <= 1'b0;
         boot_mode <= 1'b0;
         boot_readable <= 1'b0;
         cpu_hold <= 1'b0;
         block_a_mapped <= 1'b0;
         cs_two_lo <= 24'h00_0000;
         cs_two_hi <= 24'h00_0000;
         ext_expand <= 1'b0;
      end else begin
         // id check guards serial and can programmers
         pgm_accept <= pgm_req & (~ser_can | flash_blank | pgm_id_ok);
         pgm_read_ok <= parallel & ~par_block;
         pgm_write_ok <= parallel & ~par_block;
         boot_mode <= boot_q;
         boot_readable <= boot_q & ~ctrl0_q[frpc_pkg::B_AREASEL];
         cpu_hold <= (st_d == frpc_pkg::FRPC_BUSY) & inplace;
         block_a_mapped <= pm_q[frpc_pkg::B_BLKA];
         cs_two_lo <= pm_q[frpc_pkg::B_BLKA] ? frpc_pkg::CS_TWO_LO : 24'h00_0000;
         cs_two_hi <= pm_q[frpc_pkg::B_BLKA] ? frpc_pkg::CS_TWO_HI : 24'h00_0000;
         ext_expand <= pm_q[frpc_pkg::B_EXPAND];
      end
   end

   assign op_start = op_q.start;
   assign op_erase = op_q.erase;
   assign op_byte = op_q.byte_mode;
   assign hrdata = {24'h00_0000, hr_q};
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule
`default_nettype wire

// >>> testbench/frpc_props.sv
`timescale 1ns/1ps
`default_nettype none
module frpc_props #(
   parameter int OP_CYCLES = 16
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // programmer side
   input wire logic [1:0] prog_mode,
   input wire logic flash_blank,
   input wire logic pgm_req,
   input wire logic pgm_id_ok,
   input wire logic pgm_accept,
   input wire logic pgm_read_ok,
   input wire logic pgm_write_ok,
   // flash core and system
   input wire logic op_start,
   input wire logic op_byte,
   input wire logic cpu_hold,
   input wire logic block_a_mapped,
   input wire logic [23:0] cs_two_lo,
   input wire logic [23:0] cs_two_hi,
   input wire logic ext_expand
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic gate;
   logic [7:0] gap_q;
   logic [7:0] gap_d;
   // a command is taken when the id gate is open or not needed
   assign gate = pgm_req && (prog_mode == 2'd0 || prog_mode == 2'd2 || flash_blank || pgm_id_ok);
   // cycles still busy after a start; kept two short so a fast restart is not flagged
   assign gap_d = op_start ? 8'(OP_CYCLES - 2) : (gap_q != 8'h00 ? gap_q - 8'h01 : gap_q);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_q <= 8'h00;
      end else begin
         gap_q <= gap_d;
      end
   end
   sequence s_quiet;
      !op_start [*2];
   endsequence
   a_cs2_window: assert property (
      block_a_mapped |-> cs_two_lo == frpc_pkg::CS_TWO_LO && cs_two_hi == frpc_pkg::CS_TWO_HI)
      else $error("chip select two window wrong");
   a_accept_open: assert property (gate |=> pgm_accept)
      else $error("programmer command not accepted");
   a_accept_shut: assert property (!gate |=> !pgm_accept)
      else $error("programmer command accepted without id match");
   a_read_parallel: assert property (pgm_read_ok |-> $past(prog_mode) == 2'd2)
      else $error("read allowed outside parallel mode");
   a_write_parallel: assert property (pgm_write_ok |-> $past(prog_mode) == 2'd2)
      else $error("rewrite allowed outside parallel mode");
   a_byte_parallel: assert property (op_start |-> !op_byte || $past(prog_mode) == 2'd2)
      else $error("byte program outside parallel mode");
   a_start_pulse: assert property (op_start |=> s_quiet)
      else $error("start is not a single pulse");
   a_start_spacing: assert property (op_start |-> gap_q == 8'h00)
      else $error("start while the core is busy");
   a_hold_expand: assert property (cpu_hold |-> ext_expand)
      else $error("expand bit low during rewrite hold");
endmodule
bind frpc_top frpc_props #(.OP_CYCLES(OP_CYCLES)) u_props (
   .hclk(hclk), .hresetn(hresetn), .prog_mode(prog_mode), .flash_blank(flash_blank),
   .pgm_req(pgm_req), .pgm_id_ok(pgm_id_ok), .pgm_accept(pgm_accept),
   .pgm_read_ok(pgm_read_ok), .pgm_write_ok(pgm_write_ok), .op_start(op_start),
   .op_byte(op_byte), .cpu_hold(cpu_hold), .block_a_mapped(block_a_mapped),
   .cs_two_lo(cs_two_lo), .cs_two_hi(cs_two_hi), .ext_expand(ext_expand));
`default_nettype wire

// >>> testbench/frpc_pgm_model.sv
`timescale 1ns/1ps
`default_nettype none
module frpc_pgm_model (
   // clock
   input wire logic hclk,
   // bench control
   input wire logic send,
   input wire logic id_match,
   // device side
   input wire logic pgm_accept,
   output logic pgm_req,
   output logic pgm_id_ok,
   output logic [7:0] accepted
);
   initial begin
      pgm_req = 1'b0;
      pgm_id_ok = 1'b0;
      accepted = 8'h00;
   end
   // one request per send; the id verdict only stands beside a request
   always @(posedge hclk) begin
      pgm_req <= send;
      pgm_id_ok <= send & id_match;
      accepted <= accepted + {7'h00, pgm_accept};
   end
endmodule
`default_nettype wire

// >>> testbench/frpc_bench.sv
`timescale 1ns/1ps
`default_nettype none
module frpc_bench;
   localparam int OPC = 8;
   localparam logic [19:0] TBL = 20'h8_CE54;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, r;
   logic hreadyout, hresp, req, id_ok, accept, rd_ok, wr_ok, start, erase, byte_op;
   logic bmode, bread, hold, blka, expand;
   logic bsel = 1'b0;
   logic blow = 1'b0;
   logic bhigh = 1'b0;
   logic fail = 1'b0;
   logic blank = 1'b0;
   logic send = 1'b0;
   logic id_match = 1'b0;
   logic [1:0] pmode = 2'b00;
   logic [7:0] accepted, base;
   logic [3:0] vec;
   logic [23:0] lo, hi;
   int err_count = 0;
   int checks = 0;
   always #25 hclk = ~hclk;
   frpc_top #(.OP_CYCLES(OPC)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .boot_select_pin(bsel),
      .boot_strap_low_pin(blow), .boot_strap_high_pin(bhigh), .prog_mode(pmode),
      .op_fail(fail), .flash_blank(blank), .pgm_req(req), .pgm_id_ok(id_ok),
      .pgm_accept(accept), .pgm_read_ok(rd_ok), .pgm_write_ok(wr_ok), .op_start(start),
      .op_erase(erase), .op_byte(byte_op), .boot_mode(bmode), .boot_readable(bread),
      .cpu_hold(hold), .block_a_mapped(blka), .cs_two_lo(lo), .cs_two_hi(hi),
      .ext_expand(expand));
   frpc_pgm_model pgm (.hclk(hclk), .send(send), .id_match(id_match), .pgm_accept(accept),
      .pgm_req(req), .pgm_id_ok(id_ok), .accepted(accepted));
   task automatic close_out;
      if (err_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one single transfer; read data is taken at the edge closing the data phase
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      r = hrdata;
      #1;
      if (n >= 40) begin
         err_count++;
         close_out;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      xfer(1'b0, a, 32'h0000_0000);
      chk(r & m, e);
   endtask
   // set bits need a write of 0 right before the write of 1
   task automatic en(input logic [7:0] a, input logic [31:0] d);
      wr(a, 32'h0000_0000);
      wr(a, d);
   endtask
   task automatic mode(input logic [1:0] m);
      @(posedge hclk);
      pmode <= m;
      repeat (3) @(posedge hclk);
      #1;
   endtask
   task automatic wait_start;
      int n;
      n = 0;
      while (start !== 1'b1 && n < 10) begin
         @(posedge hclk);
         #1;
         n++;
      end
      if (start !== 1'b1) begin
         err_count++;
         close_out;
      end
   endtask
   task automatic poll_ready;
      int n;
      n = 0;
      do begin
         xfer(1'b0, frpc_pkg::OFF_FCTRL0, 32'h0000_0000);
         n++;
      end while (r[0] !== 1'b1 && n < 20);
      if (r[0] !== 1'b1) begin
         err_count++;
         close_out;
      end
   endtask
   // straps are sampled as reset lets go
   task automatic do_reset(input logic s, input logic l, input logic h);
      @(posedge hclk);
      hresetn <= 1'b0;
      bsel <= s;
      blow <= l;
      bhigh <= h;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      #1;
   endtask
   initial begin
      do_reset(1'b0, 1'b0, 1'b0);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0001);
      rd(frpc_pkg::OFF_PROT, 32'h0000_00FF);
      chk(hresp, 1'b0);
      // a lone 1, or 0 then a foreign write then 1, must not unlock
      wr(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      wr(frpc_pkg::OFF_FCTRL0, 32'h0000_0000);
      wr(frpc_pkg::OFF_FCTRL1, 32'h0000_0000);
      wr(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0001);
      en(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0003);
      rd(frpc_pkg::OFF_PMODE, 32'h0000_0009);
      chk({blka, expand}, 2'b11);
      chk(lo, frpc_pkg::CS_TWO_LO);
      chk(hi, frpc_pkg::CS_TWO_HI);
      // expand written high while forced: it must land only after the enable clears
      wr(frpc_pkg::OFF_PMODE, 32'h0000_0008);
      chk(expand, 1'b1);
      en(frpc_pkg::OFF_FCTRL1, 32'h0000_0002);
      wr(frpc_pkg::OFF_FCTRL0, 32'h0000_0000);
      rd(frpc_pkg::OFF_FCTRL1, 32'h0000_0000);
      chk(expand, 1'b1);
      // protect bits only clear; protection shuts parallel access
      wr(frpc_pkg::OFF_PROT, 32'h0000_00BF);
      wr(frpc_pkg::OFF_PROT, 32'h0000_00FF);
      rd(frpc_pkg::OFF_PROT, 32'h0000_00BF);
      mode(2'd2);
      chk({rd_ok, wr_ok}, 2'b00);
      rd(frpc_pkg::OFF_PROT, 32'h0000_0000);
      wr(frpc_pkg::OFF_PROT, 32'h0000_008F);
      mode(2'd0);
      rd(frpc_pkg::OFF_PROT, 32'h0000_00BF);
      wr(frpc_pkg::OFF_PROT, 32'h0000_008F);
      mode(2'd2);
      chk({rd_ok, wr_ok}, 2'b11);
      // programmer id gate, entries {mode, blank, id match}
      for (int i = 0; i < 5; i++) begin
         vec = TBL[4*i +: 4];
         @(posedge hclk);
         pmode <= vec[3:2];
         blank <= vec[1];
         id_match <= vec[0];
         send <= 1'b1;
         base = accepted;
         @(posedge hclk);
         send <= 1'b0;
         repeat (4) @(posedge hclk);
         #1;
         chk(accepted - base, {7'h00, vec[3:2] == 2'd0 || vec[3:2] == 2'd2 || |vec[1:0]});
      end
      // unprotected parallel programmer may program bytes without the enable
      wr(frpc_pkg::OFF_CMD, 32'h0000_0005);
      wait_start;
      chk({erase, byte_op}, 2'b01);
      poll_ready;
      mode(2'd0);
      // failing word program from ram, byte request refused outside parallel mode
      @(posedge hclk);
      fail <= 1'b1;
      en(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      wr(frpc_pkg::OFF_CMD, 32'h0000_0005);
      wait_start;
      chk({erase, byte_op}, 2'b00);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      poll_ready;
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0043);
      rd(frpc_pkg::OFF_STAT, 32'h0000_0090);
      rd(frpc_pkg::OFF_MAP, 32'h0000_0001, 32'h0000_0001);
      wr(frpc_pkg::OFF_CMD, 32'h0000_0003);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0003);
      // in-place erase holds the cpu and restores the protect byte
      @(posedge hclk);
      fail <= 1'b0;
      en(frpc_pkg::OFF_FCTRL1, 32'h0000_0002);
      wr(frpc_pkg::OFF_CMD, 32'h0000_0002);
      wait_start;
      chk(erase, 1'b1);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      chk(hold, 1'b1);
      poll_ready;
      chk(hold, 1'b0);
      rd(frpc_pkg::OFF_MAP, 32'h0000_0000, 32'h0000_0001);
      rd(frpc_pkg::OFF_STAT, 32'h0000_0000);
      rd(frpc_pkg::OFF_PROT, 32'h0000_00FF);
      wr(frpc_pkg::OFF_FCTRL0, 32'h0000_0000);
      // boot straps and area select
      do_reset(1'b1, 1'b0, 1'b1);
      chk({bmode, bread}, 2'b11);
      // boot area selected: a cpu rewrite command must not start
      en(frpc_pkg::OFF_FCTRL0, 32'h0000_0002);
      wr(frpc_pkg::OFF_CMD, 32'h0000_0001);
      chk(start, 1'b0);
      wr(frpc_pkg::OFF_FCTRL0, 32'h0000_0020);
      rd(frpc_pkg::OFF_FCTRL0, 32'h0000_0021);
      chk(bread, 1'b0);
      do_reset(1'b0, 1'b0, 1'b1);
      chk({bmode, bread}, 2'b00);
      close_out;
   end
endmodule
`default_nettype wire
